/* File: isrp_pkg.sv */
// Shared constants and types for the touch controller serial register port
package isrp_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int BIT_RATE_HZ = 100_000;
	localparam int QTR_CYC = CLK_HZ / (4 * BIT_RATE_HZ);
	localparam int PWR_NORMAL_MS = 350;
	localparam int PWR_HIGH_MS = 1000;
	localparam int GAP_MS = 60;
	localparam int PWR_NORMAL_CYC = PWR_NORMAL_MS * (CLK_HZ / 1000);
	localparam int PWR_HIGH_CYC = PWR_HIGH_MS * (CLK_HZ / 1000);
	localparam int GAP_CYC = GAP_MS * (CLK_HZ / 1000);
	localparam int WAIT_W = 24;
	localparam int BUF_BYTES = 32;
	localparam int MAP_AW = 5;
	localparam int LEN_W = 6;
	localparam logic [6:0] DEF_SLAVE_ADDR = 7'h37;
	localparam logic [7:0] PTR_RESET_ADDR = 8'h00;

	typedef enum logic [3:0] {
		DS_IDLE, DS_ADDR, DS_ADDR_ACK, DS_REGA, DS_REGA_ACK,
		DS_WDATA, DS_WDATA_ACK, DS_RDATA, DS_RDATA_ACK, DS_IGNORE
	} isrp_dev_state_t;

	typedef enum logic [2:0] {
		HS_IDLE, HS_WAIT, HS_START, HS_BIT, HS_STOP
	} isrp_host_state_t;

	typedef enum logic [1:0] {
		STG_ADDR, STG_REG, STG_DATA
	} isrp_stage_t;

	// Open-drain: enable low only while the wanted level is zero
	function automatic logic isrp_od_oe_n(input logic bit_val);
		return bit_val;
	endfunction
endpackage

/* File: isrp_if.sv */
// Two-wire bus plus alert line joining host and device ends
`timescale 1ns/1ps
interface isrp_if;
	logic scl_o;
	logic scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic host_alert_o;
	logic host_alert_oe_n;
	logic dev_alert_o;
	logic dev_alert_oe_n;
	logic scl;
	logic sda;
	logic alert;

	// Pull-ups resolve released lines to one
	assign scl = scl_oe_n | scl_o;
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
	assign alert = (host_alert_oe_n | host_alert_o) & (dev_alert_oe_n | dev_alert_o);

	modport host (
		output scl_o, scl_oe_n, host_sda_o, host_sda_oe_n, host_alert_o, host_alert_oe_n,
		input scl, sda, alert
	);
	modport device (
		output dev_sda_o, dev_sda_oe_n, dev_alert_o, dev_alert_oe_n,
		input scl, sda, alert
	);
endinterface

/* File: isrp_sync.sv */
// Two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module isrp_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_ff <= '0;
			q_o <= '0;
		end
		else
		begin
			meta_ff <= d_i;
			q_o <= meta_ff;
		end
	end
endmodule

/* File: isrp_device.sv */
// Device end: serial slave register port with alert line
`timescale 1ns/1ps
module isrp_device
	import isrp_pkg::*;
#(
	parameter int PWR_NORMAL_WAIT = PWR_NORMAL_CYC,
	parameter int PWR_HIGH_WAIT = PWR_HIGH_CYC,
	parameter int GAP_WAIT = GAP_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic link_clk_i,
	isrp_if.device bus,
	input wire logic [6:0] dev_addr_i,
	input wire logic noise_high_i,
	input wire logic touch_i,
	input wire logic upd_valid_i,
	input wire logic [MAP_AW-1:0] upd_addr_i,
	input wire logic [7:0] upd_data_i,
	output logic upd_ready_o,
	output logic wr_valid_o,
	output logic [MAP_AW-1:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	output logic ready_o
);
	// Link domain
	logic [2:0] pin_s;
	logic [9:0] cfg_s;
	logic scl_s, sda_s, alert_s, scl_q_ff, sda_q_ff;
	logic upd_req_s, gap_ok_s, ready_s;
	logic [6:0] addr_s;
	logic start_c, stop_c, rise_c, fall_c, byte_c, addr_hit_c, wr_hit_c, snap_load_c;
	isrp_dev_state_t st_ff;
	logic [3:0] bitcnt_ff;
	logic [7:0] sh_ff, tx_ff;
	logic [MAP_AW-1:0] ptr_ff;
	logic [LEN_W-1:0] wcnt_ff;
	logic rw_ff, mack_ff, sda_oe_n_ff;
	// Single register set, always the run-time one
	logic [7:0] map_ff [BUF_BYTES];
	logic [7:0] snap_ff [BUF_BYTES];
	logic wr_t_ff, stop_t_ff, upd_seen_ff;
	logic [MAP_AW-1:0] wr_addr_l_ff;
	logic [7:0] wr_data_l_ff;
	// System domain
	logic [2:0] ev_s;
	logic wr_seen_ff, stop_seen_ff, upd_req_ff, boot_ff, alert_oe_n_ff, gap_ok_ff;
	logic [MAP_AW-1:0] upd_addr_ff;
	logic [7:0] upd_data_ff;
	logic [WAIT_W-1:0] pu_cnt_ff, gap_cnt_ff;

	isrp_sync #(.W(3)) u_pin_sync (
		.clk_i(link_clk_i),
		.rst_n_i(rst_n_i),
		.d_i({bus.scl, bus.sda, bus.alert}),
		.q_o(pin_s)
	);
	// Address is quasi-static, so bit skew during a change is harmless
	isrp_sync #(.W(10)) u_cfg_sync (
		.clk_i(link_clk_i),
		.rst_n_i(rst_n_i),
		.d_i({upd_req_ff, gap_ok_ff, ready_o, dev_addr_i}),
		.q_o(cfg_s)
	);
	isrp_sync #(.W(3)) u_ev_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i({wr_t_ff, stop_t_ff, upd_seen_ff}),
		.q_o(ev_s)
	);

	assign {scl_s, sda_s, alert_s} = pin_s;
	assign {upd_req_s, gap_ok_s, ready_s, addr_s} = cfg_s;

	assign start_c = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
	assign stop_c = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
	assign rise_c = scl_s & ~scl_q_ff;
	assign fall_c = ~scl_s & scl_q_ff;
	assign byte_c = fall_c && bitcnt_ff == 4'h8;
	assign addr_hit_c = sh_ff[7:1] == addr_s && ready_s && !alert_s;
	assign wr_hit_c = st_ff == DS_WDATA && byte_c && wcnt_ff < LEN_W'(BUF_BYTES);
	assign snap_load_c = st_ff == DS_ADDR && byte_c && addr_hit_c && sh_ff[0] && gap_ok_s;

	// Only the data and alert lines are ever driven; the clock is left to the master
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe_n = sda_oe_n_ff;
	assign bus.dev_alert_o = 1'b0;
	assign bus.dev_alert_oe_n = alert_oe_n_ff;

	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			scl_q_ff <= 1'b0;
			sda_q_ff <= 1'b0;
		end
		else
		begin
			scl_q_ff <= scl_s;
			sda_q_ff <= sda_s;
		end
	end

	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_ff <= DS_IDLE;
			bitcnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			tx_ff <= 8'h00;
			ptr_ff <= MAP_AW'(PTR_RESET_ADDR);
			wcnt_ff <= '0;
			rw_ff <= 1'b0;
			mack_ff <= 1'b0;
			sda_oe_n_ff <= 1'b1;
		end
		else if (start_c)
		begin
			st_ff <= DS_ADDR;
			bitcnt_ff <= 4'h0;
			sda_oe_n_ff <= 1'b1;
		end
		else if (stop_c)
		begin
			st_ff <= DS_IDLE;
			sda_oe_n_ff <= 1'b1;
		end
		else
		begin
			case (st_ff)
				DS_ADDR, DS_REGA, DS_WDATA:
				begin
					if (rise_c)
					begin
						sh_ff <= {sh_ff[6:0], sda_s};
						bitcnt_ff <= bitcnt_ff + 4'h1;
					end
					if (byte_c)
					begin
						bitcnt_ff <= 4'h0;
						if (st_ff == DS_ADDR)
						begin
							if (addr_hit_c)
							begin
								sda_oe_n_ff <= 1'b0;
								rw_ff <= sh_ff[0];
								st_ff <= DS_ADDR_ACK;
							end
							else
								st_ff <= DS_IGNORE;
						end
						else if (st_ff == DS_REGA)
						begin
							ptr_ff <= sh_ff[MAP_AW-1:0];
							wcnt_ff <= '0;
							sda_oe_n_ff <= 1'b0;
							st_ff <= DS_REGA_ACK;
						end
						else if (wr_hit_c)
						begin
							ptr_ff <= ptr_ff + 1'b1;
							wcnt_ff <= wcnt_ff + 1'b1;
							sda_oe_n_ff <= 1'b0;
							st_ff <= DS_WDATA_ACK;
						end
						else
							st_ff <= DS_IGNORE;
					end
				end
				DS_ADDR_ACK:
				begin
					if (fall_c && rw_ff)
					begin
						tx_ff <= snap_ff[ptr_ff];
						sda_oe_n_ff <= isrp_od_oe_n(snap_ff[ptr_ff][7]);
						ptr_ff <= ptr_ff + 1'b1;
						st_ff <= DS_RDATA;
					end
					else if (fall_c)
					begin
						sda_oe_n_ff <= 1'b1;
						st_ff <= DS_REGA;
					end
				end
				DS_REGA_ACK, DS_WDATA_ACK:
				begin
					if (fall_c)
					begin
						sda_oe_n_ff <= 1'b1;
						st_ff <= DS_WDATA;
					end
				end
				DS_RDATA:
				begin
					if (rise_c)
						bitcnt_ff <= bitcnt_ff + 4'h1;
					if (byte_c)
					begin
						bitcnt_ff <= 4'h0;
						sda_oe_n_ff <= 1'b1;
						st_ff <= DS_RDATA_ACK;
					end
					else if (fall_c)
					begin
						tx_ff <= {tx_ff[6:0], 1'b0};
						sda_oe_n_ff <= isrp_od_oe_n(tx_ff[6]);
					end
				end
				DS_RDATA_ACK:
				begin
					if (rise_c)
						mack_ff <= ~sda_s;
					if (fall_c && mack_ff)
					begin
						tx_ff <= snap_ff[ptr_ff];
						sda_oe_n_ff <= isrp_od_oe_n(snap_ff[ptr_ff][7]);
						ptr_ff <= ptr_ff + 1'b1;
						st_ff <= DS_RDATA;
					end
					else if (fall_c)
						st_ff <= DS_IGNORE;
				end
				DS_IDLE, DS_IGNORE:
				begin
				end
				default:
					st_ff <= DS_IDLE;
			endcase
		end
	end

	// Bus write wins over a local update arriving in the same cycle
	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < BUF_BYTES; i++)
				map_ff[i] <= 8'h00;
			upd_seen_ff <= 1'b0;
		end
		else
		begin
			upd_seen_ff <= upd_req_s;
			if (upd_req_s != upd_seen_ff)
				map_ff[upd_addr_ff] <= upd_data_ff;
			if (wr_hit_c)
				map_ff[ptr_ff] <= sh_ff;
		end
	end

	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < BUF_BYTES; i++)
				snap_ff[i] <= 8'h00;
		end
		else if (snap_load_c)
		begin
			for (int i = 0; i < BUF_BYTES; i++)
				snap_ff[i] <= map_ff[i];
		end
	end

	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_t_ff <= 1'b0;
			stop_t_ff <= 1'b0;
			wr_addr_l_ff <= '0;
			wr_data_l_ff <= 8'h00;
		end
		else
		begin
			if (wr_hit_c)
			begin
				wr_t_ff <= ~wr_t_ff;
				wr_addr_l_ff <= ptr_ff;
				wr_data_l_ff <= sh_ff;
			end
			if (stop_c && st_ff != DS_IDLE)
				stop_t_ff <= ~stop_t_ff;
		end
	end

	// System domain: timers, alert, user side of the crossings
	assign upd_ready_o = upd_req_ff == ev_s[0];

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_seen_ff <= 1'b0;
			wr_valid_o <= 1'b0;
			wr_addr_o <= '0;
			wr_data_o <= 8'h00;
		end
		else
		begin
			wr_seen_ff <= ev_s[2];
			wr_valid_o <= ev_s[2] != wr_seen_ff;
			if (ev_s[2] != wr_seen_ff)
			begin
				wr_addr_o <= wr_addr_l_ff;
				wr_data_o <= wr_data_l_ff;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			upd_req_ff <= 1'b0;
			upd_addr_ff <= '0;
			upd_data_ff <= 8'h00;
		end
		else if (upd_valid_i && upd_ready_o)
		begin
			upd_req_ff <= ~upd_req_ff;
			upd_addr_ff <= upd_addr_i;
			upd_data_ff <= upd_data_i;
		end
	end

	// Power-on hold-off is chosen on the first clock after reset
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			boot_ff <= 1'b1;
			pu_cnt_ff <= '0;
			ready_o <= 1'b0;
		end
		else
		begin
			boot_ff <= 1'b0;
			if (boot_ff)
				pu_cnt_ff <= noise_high_i ? WAIT_W'(PWR_HIGH_WAIT) : WAIT_W'(PWR_NORMAL_WAIT);
			else if (pu_cnt_ff != '0)
				pu_cnt_ff <= pu_cnt_ff - 1'b1;
			ready_o <= !boot_ff && pu_cnt_ff == '0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			stop_seen_ff <= 1'b0;
			gap_cnt_ff <= '0;
			gap_ok_ff <= 1'b1;
			alert_oe_n_ff <= 1'b1;
		end
		else
		begin
			stop_seen_ff <= ev_s[1];
			if (ev_s[1] != stop_seen_ff)
				gap_cnt_ff <= WAIT_W'(GAP_WAIT);
			else if (gap_cnt_ff != '0)
				gap_cnt_ff <= gap_cnt_ff - 1'b1;
			// Registered so no compare glitch reaches the synchroniser
			gap_ok_ff <= gap_cnt_ff == '0;
			alert_oe_n_ff <= ~touch_i;
		end
	end
endmodule

/* File: isrp_host.sv */
// Host end: two-wire bus master driving the device's register port
`timescale 1ns/1ps
module isrp_host
	import isrp_pkg::*;
#(
	parameter int PWR_NORMAL_WAIT = PWR_NORMAL_CYC,
	parameter int PWR_HIGH_WAIT = PWR_HIGH_CYC,
	parameter int GAP_WAIT = GAP_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	isrp_if.host bus,
	input wire logic go_i,
	input wire logic rd_i,
	input wire logic [6:0] dev_addr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [LEN_W-1:0] len_i,
	input wire logic long_wait_i,
	input wire logic noise_high_i,
	input wire logic [7:0] wr_data_i,
	output logic wr_take_o,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic done_o,
	output logic nack_o,
	output logic busy_o
);
	logic sda_s, tick_c, rx_mode_c;
	isrp_host_state_t st_ff;
	isrp_stage_t stage_ff;
	logic [4:0] div_ff;
	logic [1:0] ph_ff;
	logic [3:0] bitn_ff;
	logic [7:0] tx_ff, rx_ff, reg_ff;
	logic [LEN_W-1:0] rem_ff;
	logic rd_ff, long_ff, boot_ff, scl_oe_n_ff, sda_oe_n_ff, alert_oe_n_ff;
	logic [WAIT_W-1:0] wait_ff;

	isrp_sync #(.W(1)) u_sda_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i(bus.sda),
		.q_o(sda_s)
	);

	assign bus.scl_o = 1'b0;
	assign bus.scl_oe_n = scl_oe_n_ff;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe_n = sda_oe_n_ff;
	assign bus.host_alert_o = 1'b0;
	assign bus.host_alert_oe_n = alert_oe_n_ff;
	assign tick_c = div_ff == 5'(QTR_CYC - 1);
	assign rx_mode_c = stage_ff == STG_DATA && rd_ff;
	assign busy_o = st_ff != HS_IDLE || wait_ff != '0 || boot_ff;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			div_ff <= 5'h00;
		else if (st_ff == HS_IDLE || tick_c)
			div_ff <= 5'h00;
		else
			div_ff <= div_ff + 5'h01;
	end

	// Hold-off after power-on, after each stop, and after long commands
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			boot_ff <= 1'b1;
			wait_ff <= '0;
		end
		else
		begin
			boot_ff <= 1'b0;
			if (boot_ff)
				wait_ff <= noise_high_i ? WAIT_W'(PWR_HIGH_WAIT) : WAIT_W'(PWR_NORMAL_WAIT);
			else if (st_ff == HS_STOP && tick_c && ph_ff == 2'h3)
			begin
				if (!long_ff)
					wait_ff <= WAIT_W'(GAP_WAIT);
				else
					wait_ff <= noise_high_i ? WAIT_W'(PWR_HIGH_WAIT) : WAIT_W'(PWR_NORMAL_WAIT);
			end
			else if (wait_ff != '0)
				wait_ff <= wait_ff - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_ff <= HS_IDLE;
			stage_ff <= STG_ADDR;
			ph_ff <= 2'h0;
			bitn_ff <= 4'h0;
			tx_ff <= 8'h00;
			rx_ff <= 8'h00;
			reg_ff <= 8'h00;
			rem_ff <= '0;
			rd_ff <= 1'b0;
			long_ff <= 1'b0;
			scl_oe_n_ff <= 1'b1;
			sda_oe_n_ff <= 1'b1;
			alert_oe_n_ff <= 1'b1;
			wr_take_o <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_data_o <= 8'h00;
			done_o <= 1'b0;
			nack_o <= 1'b0;
		end
		else
		begin
			wr_take_o <= 1'b0;
			rd_valid_o <= 1'b0;
			done_o <= 1'b0;
			if (tick_c && st_ff != HS_IDLE)
				ph_ff <= ph_ff + 2'h1;
			case (st_ff)
				HS_IDLE:
				begin
					ph_ff <= 2'h0;
					if (go_i && !busy_o)
					begin
						rd_ff <= rd_i;
						reg_ff <= reg_addr_i;
						rem_ff <= len_i;
						long_ff <= long_wait_i;
						tx_ff <= {dev_addr_i, rd_i};
						nack_o <= 1'b0;
						alert_oe_n_ff <= 1'b0;
						st_ff <= HS_WAIT;
					end
				end
				HS_WAIT:
				begin
					if (tick_c && ph_ff == 2'h3)
						st_ff <= HS_START;
				end
				HS_START:
				begin
					if (tick_c)
					begin
						if (ph_ff == 2'h0)
							sda_oe_n_ff <= 1'b0;
						if (ph_ff == 2'h2)
							scl_oe_n_ff <= 1'b0;
						if (ph_ff == 2'h3)
						begin
							stage_ff <= STG_ADDR;
							bitn_ff <= 4'h0;
							st_ff <= HS_BIT;
						end
					end
				end
				HS_BIT:
				begin
					if (tick_c && ph_ff == 2'h0)
					begin
						if (bitn_ff == 4'h8)
							sda_oe_n_ff <= rx_mode_c ? rem_ff == LEN_W'(1) : 1'b1;
						else
							sda_oe_n_ff <= rx_mode_c ? 1'b1 : isrp_od_oe_n(tx_ff[7]);
					end
					if (tick_c && ph_ff == 2'h1)
						scl_oe_n_ff <= 1'b1;
					if (tick_c && ph_ff == 2'h2)
					begin
						if (bitn_ff != 4'h8)
							rx_ff <= {rx_ff[6:0], sda_s};
						else if (!rx_mode_c)
							nack_o <= sda_s;
					end
					if (tick_c && ph_ff == 2'h3)
					begin
						scl_oe_n_ff <= 1'b0;
						bitn_ff <= bitn_ff + 4'h1;
						tx_ff <= {tx_ff[6:0], 1'b0};
						if (bitn_ff == 4'h8)
						begin
							bitn_ff <= 4'h0;
							if (rx_mode_c)
							begin
								rd_valid_o <= 1'b1;
								rd_data_o <= rx_ff;
								rem_ff <= rem_ff - 1'b1;
								if (rem_ff == LEN_W'(1))
									st_ff <= HS_STOP;
							end
							else if (nack_o)
								st_ff <= HS_STOP;
							else if (stage_ff == STG_ADDR && rd_ff)
							begin
								stage_ff <= STG_DATA;
								if (rem_ff == '0)
									st_ff <= HS_STOP;
							end
							else if (stage_ff == STG_ADDR)
							begin
								stage_ff <= STG_REG;
								tx_ff <= reg_ff;
							end
							else if (rem_ff == '0 || (stage_ff == STG_DATA && rem_ff == LEN_W'(1)))
								st_ff <= HS_STOP;
							else
							begin
								if (stage_ff == STG_DATA)
									rem_ff <= rem_ff - 1'b1;
								stage_ff <= STG_DATA;
								tx_ff <= wr_data_i;
								wr_take_o <= 1'b1;
							end
						end
					end
				end
				HS_STOP:
				begin
					if (tick_c)
					begin
						if (ph_ff == 2'h0)
							sda_oe_n_ff <= 1'b0;
						if (ph_ff == 2'h1)
							scl_oe_n_ff <= 1'b1;
						if (ph_ff == 2'h2)
							sda_oe_n_ff <= 1'b1;
						if (ph_ff == 2'h3)
						begin
							alert_oe_n_ff <= 1'b1;
							done_o <= 1'b1;
							st_ff <= HS_IDLE;
						end
					end
				end
				default:
					st_ff <= HS_IDLE;
			endcase
		end
	end
endmodule

/* File: isrp_checker.sv */
// Protocol checker on the shared two-wire bus and alert line
`timescale 1ns/1ps
module isrp_checker #(
	parameter logic [6:0] ADDR = 7'h37
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic scl_oe_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic alert,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic dev_alert_o,
	input wire logic dev_alert_oe_n
);
	logic scl_q, sda_q, busy_ff, rd_ff, seen_ff;
	logic [3:0] cnt_ff;
	logic [5:0] byte_ff;
	logic [6:0] addr_ff;
	logic [7:0] per_ff;
	wire start_w = scl && scl_q && sda_q && !sda;
	wire stop_w = scl && scl_q && !sda_q && sda;
	wire rise_w = scl && !scl_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
			per_ff <= 8'h00;
			seen_ff <= 1'h0;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			per_ff <= rise_w ? 8'h00 : per_ff + {7'h00, per_ff != 8'hFF};
			seen_ff <= seen_ff | rise_w;
		end

	// Frame position: bit index within byte, byte index, address and direction
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			busy_ff <= 1'h0;
			cnt_ff <= 4'h0;
			byte_ff <= 6'h00;
			rd_ff <= 1'h0;
			addr_ff <= 7'h00;
		end
		else if (start_w)
		begin
			busy_ff <= 1'h1;
			cnt_ff <= 4'h0;
			byte_ff <= 6'h00;
		end
		else if (stop_w)
			busy_ff <= 1'h0;
		else if (rise_w && busy_ff)
		begin
			if (byte_ff == 6'h00 && cnt_ff < 4'h7)
				addr_ff <= {addr_ff[5:0], sda};
			if (byte_ff == 6'h00 && cnt_ff == 4'h7)
				rd_ff <= sda;
			cnt_ff <= (cnt_ff == 4'h8) ? 4'h0 : cnt_ff + 4'h1;
			if (cnt_ff == 4'h8)
				byte_ff <= byte_ff + 6'h01;
		end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_no_clock_stretch: assert property (scl_oe_n |-> scl)
		else $error("clock line low while host released it");
	a_bit_rate_limit: assert property (rise_w && seen_ff |-> per_ff >= 8'h63)
		else $error("clock period shorter than 100 cycles");
	a_sda_open_drain: assert property (!dev_sda_oe_n |-> dev_sda_o == 1'h0)
		else $error("device data line driven high");
	a_alert_open_drain: assert property (!dev_alert_oe_n |-> !dev_alert_o)
		else $error("device alert line driven high");
	a_alert_at_start: assert property (start_w |-> !alert)
		else $error("start while alert line high");
	a_foreign_addr_quiet: assert property (
		busy_ff && (byte_ff != 6'h00 || cnt_ff == 4'h8) && addr_ff != ADDR |-> dev_sda_oe_n)
		else $error("device drove bus for another address");
	a_idle_bus_released: assert property (!busy_ff |-> dev_sda_oe_n)
		else $error("device drove data line outside a transaction");
	a_stable_clock_high: assert property (scl && scl_q |-> $stable(dev_sda_oe_n))
		else $error("device changed data line while clock high");
	a_write_bits_free: assert property (
		rise_w && busy_ff && (byte_ff == 6'h00 || !rd_ff) && cnt_ff != 4'h8 |-> dev_sda_oe_n)
		else $error("device drove a host data bit");
	a_host_ack_slot: assert property (
		rise_w && busy_ff && rd_ff && byte_ff != 6'h00 && cnt_ff == 4'h8 |-> dev_sda_oe_n)
		else $error("device drove the host acknowledge slot");

	c_read_four: cover property (rise_w && rd_ff && byte_ff == 6'h04);
	c_full_write: cover property (stop_w && byte_ff == 6'h22);
	c_foreign: cover property (busy_ff && byte_ff != 6'h00 && addr_ff != ADDR);
endmodule

/* File: isrp_tb.sv */
// Self-checking bench joining host and device ends over the bus
`timescale 1ns/1ps
module isrp_tb;
	import isrp_pkg::*;
	localparam int PW = 200;
	logic clk_i = 1'h0;
	logic link_clk = 1'h0;
	logic rst_n_i = 1'h0;
	logic go_i = 1'h0, rd_i = 1'h0, long_wait_i = 1'h0, touch_i = 1'h0, upd_valid_i = 1'h0;
	logic noise_high_i = 1'h0;
	logic [6:0] h_addr = 7'h37;
	logic [7:0] wr_data_i = 8'h00, upd_data_i = 8'h00, rd_data_o, wr_data_o;
	logic [LEN_W-1:0] len_i = '0;
	logic [MAP_AW-1:0] upd_addr_i = '0, wr_addr_o;
	logic wr_take_o, rd_valid_o, done_o, nack_o, busy_o, upd_ready_o, wr_valid_o, ready_o;
	int n_errors = 0;
	int samples_checked = 0;
	int n_take = 0;
	logic [7:0] wq[$], rq[$];
	logic [12:0] dq[$];

	isrp_if bus();
	isrp_host #(.PWR_NORMAL_WAIT(PW), .PWR_HIGH_WAIT(2 * PW), .GAP_WAIT(100)) u_isrp_host (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus), .go_i(go_i), .rd_i(rd_i),
		.dev_addr_i(h_addr), .reg_addr_i(8'h00), .len_i(len_i), .long_wait_i(long_wait_i),
		.noise_high_i(noise_high_i), .wr_data_i(wr_data_i), .wr_take_o(wr_take_o),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .done_o(done_o), .nack_o(nack_o),
		.busy_o(busy_o));
	isrp_device #(.PWR_NORMAL_WAIT(PW), .PWR_HIGH_WAIT(2 * PW), .GAP_WAIT(100)) u_isrp_device (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk), .bus(bus),
		.dev_addr_i(7'h37), .noise_high_i(noise_high_i), .touch_i(touch_i),
		.upd_valid_i(upd_valid_i),
		.upd_addr_i(upd_addr_i), .upd_data_i(upd_data_i), .upd_ready_o(upd_ready_o),
		.wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
		.ready_o(ready_o));
	isrp_checker u_isrp_checker (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_oe_n(bus.scl_oe_n), .scl(bus.scl), .sda(bus.sda),
		.alert(bus.alert), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe_n(bus.dev_sda_oe_n),
		.dev_alert_o(bus.dev_alert_o), .dev_alert_oe_n(bus.dev_alert_oe_n));

	initial
		forever #50 clk_i = ~clk_i;
	initial
	begin
		#3;
		forever #7.5 link_clk = ~link_clk;
	end

	always @(negedge clk_i)
		if (wr_valid_o === 1'h1)
			dq.push_back({wr_addr_o, wr_data_o});

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One host transaction; write bytes come from wq, read bytes land in rq
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [5:0] n);
		n_take = 0;
		rq = {};
		dq = {};
		while (busy_o !== 1'h0)
		begin
			@(posedge clk_i);
			#1;
		end
		@(posedge clk_i);
		go_i <= 1'h1;
		rd_i <= rd;
		h_addr <= a;
		len_i <= n;
		@(posedge clk_i);
		go_i <= 1'h0;
		while (done_o !== 1'h1)
		begin
			@(posedge clk_i);
			if (n_take < wq.size())
				wr_data_i <= wq[n_take];
			#1;
			if (wr_take_o === 1'h1)
				n_take++;
			if (rd_valid_o === 1'h1)
				rq.push_back(rd_data_o);
		end
		repeat (20) @(posedge clk_i);
	endtask

	task automatic chkw(input int n);
		chk(16'(n_take), 16'(n));
		chk(16'(dq.size()), 16'(n));
		for (int i = 0; i < n; i++)
			chk(16'(dq[i]), {3'h0, i[4:0], wq[i]});
	endtask

	task automatic chkr(input int n);
		chk(16'(rq.size()), 16'(n));
		for (int i = 0; i < n; i++)
			chk(16'(rq[i]), 16'(wq[i]));
	endtask

	initial
	begin
		#(95000 * 100);
		n_errors++;
		conclude();
	end

	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'h1;
		repeat (150) @(posedge clk_i);
		#1 chk(16'(ready_o), 16'h0000);
		repeat (100) @(posedge clk_i);
		#1 chk(16'(ready_o), 16'h0001);
		wq = {8'hA1, 8'hB2, 8'hC3};
		xfer(1'h0, 7'h37, 6'h03);
		chk(16'(nack_o), 16'h0000);
		chkw(3);
		xfer(1'h0, 7'h37, 6'h00);
		chk(16'(nack_o), 16'h0000);
		chkw(0);
		// Local map update lands between bus accesses
		while (upd_ready_o !== 1'h1)
			@(posedge clk_i);
		@(posedge clk_i);
		upd_addr_i <= 5'h03;
		upd_data_i <= 8'h5A;
		upd_valid_i <= 1'h1;
		@(posedge clk_i);
		upd_valid_i <= 1'h0;
		wq = {8'hA1, 8'hB2, 8'hC3, 8'h5A};
		xfer(1'h1, 7'h37, 6'h04);
		chk(16'(nack_o), 16'h0000);
		chkr(4);
		wq = {8'h77};
		xfer(1'h0, 7'h12, 6'h01);
		chk(16'(nack_o), 16'h0001);
		chkw(0);
		@(posedge clk_i);
		touch_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		#1 chk(16'(bus.alert), 16'h0000);
		@(posedge clk_i);
		touch_i <= 1'h0;
		repeat (4) @(posedge clk_i);
		#1 chk(16'(bus.alert), 16'h0001);
		wq = {};
		for (int i = 0; i < 32; i++)
			wq.push_back(8'h40 + 8'(i));
		xfer(1'h0, 7'h37, 6'h20);
		chk(16'(nack_o), 16'h0000);
		chkw(32);
		xfer(1'h1, 7'h37, 6'h02);
		chkr(2);
		// Mid-run reset with the long power-on hold-off selected
		noise_high_i <= 1'h1;
		rst_n_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'h1;
		repeat (300) @(posedge clk_i);
		#1 chk(16'(ready_o), 16'h0000);
		chk(16'(busy_o), 16'h0001);
		repeat (150) @(posedge clk_i);
		#1 chk(16'(ready_o), 16'h0001);
		@(posedge clk_i);
		long_wait_i <= 1'h1;
		xfer(1'h0, 7'h37, 6'h00);
		long_wait_i <= 1'h0;
		repeat (280) @(posedge clk_i);
		#1 chk(16'(busy_o), 16'h0001);
		wq = {8'h00, 8'h00};
		xfer(1'h1, 7'h37, 6'h02);
		chkr(2);
		conclude();
	end
endmodule
